/* File: hw/flc_pkg.sv */
`default_nettype none

package flc_pkg;

  // Clock and flash bus timing, in nanoseconds (protect pulse in microseconds) as printed, then in cycles.
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_WP_NS       = 55;
  localparam int T_WPH_NS      = 20;
  localparam int T_ACC_NS      = 120;
  localparam int T_OES_NS      = 50;
  localparam int T_PROT_US     = 100;
  localparam int WP_CYC        = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPH_CYC       = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC       = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OES_CYC       = (T_OES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROT_CYC      = (T_PROT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Widths.
  localparam int DATA_W = 8;
  localparam int ADDR_W = 20;
  localparam int TMR_W  = 16;

  // Status bit positions on the data bus.
  localparam int POLLING_BIT        = 7;
  localparam int TOGGLE_BIT_ONE     = 6;
  localparam int EXCEEDED_TIME_FLAG = 5;
  localparam int ERASE_WINDOW_FLAG  = 3;
  localparam int PROTECT_STATUS_BIT = 0;

  // Address lines with a special meaning.
  localparam int ID_MODE_ADDRESS_LINE  = 9;
  localparam int PROTECT_SELECT_LINE   = 6;
  localparam int ID_SELECT_ADDRESS_BIT = 1;

  // Command data that returns the device to read mode.
  localparam logic [7:0] RESET_CMD = 8'hf0;

  typedef enum logic [2:0] {
    FLC_OP_READ,
    FLC_OP_WRITE,
    FLC_OP_CHK_WRITE,
    FLC_OP_POLL,
    FLC_OP_RESET,
    FLC_OP_PROTECT,
    FLC_OP_UNPROTECT,
    FLC_OP_VERIFY
  } flc_op_t;

endpackage : flc_pkg

`default_nettype wire

/* File: hw/flc_wait.sv */
`default_nettype none

module flc_wait #(
  parameter int W = 16
) (
  // Clock and reset.
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  // Load and expiry.
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  output logic              zero_o
);

  logic [W-1:0] cnt_r;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (load_i) begin
      cnt_r <= count_i;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  assign zero_o = (cnt_r == '0);

endmodule : flc_wait

`default_nettype wire

/* File: hw/flc_host.sv */
`default_nettype none

module flc_host #(
  parameter int unsigned PROT_PULSE_CYC = flc_pkg::PROT_CYC
) (
  // Clock and reset.
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_i,
  // User command port.
  input  wire logic                        start_i,
  input  wire logic [2:0]                  op_i,
  input  wire logic [flc_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [flc_pkg::DATA_W-1:0]  wdata_i,
  input  wire logic                        tmp_unprot_i,
  output logic                             busy_o,
  output logic                             done_o,
  output logic [flc_pkg::DATA_W-1:0]       rdata_o,
  output logic                             timeout_o,
  output logic                             rejected_o,
  output logic                             refused_o,
  output logic                             locked_o,
  // Flash pins.
  output logic [flc_pkg::ADDR_W-1:0]       fl_addr_o,
  input  wire logic [flc_pkg::DATA_W-1:0]  fl_dq_i,
  output logic [flc_pkg::DATA_W-1:0]       fl_dq_o,
  output logic                             fl_dq_oe_o,
  output logic                             fl_ce_n_o,
  output logic                             fl_oe_n_o,
  output logic                             fl_we_n_o,
  output logic                             fl_reset_hv_o,
  output logic                             fl_oe_hv_o,
  output logic                             fl_idmode_hv_o
);

  typedef enum logic [2:0] {
    S_IDLE, S_WR_LOW, S_WR_HIGH, S_RD_LOW, S_RD_END, S_HV_SETUP, S_HV_PULSE, S_HV_HOLD
  } flc_state_t;

  typedef enum logic [2:0] {ACT_NONE, ACT_RD, ACT_WR, ACT_HV, ACT_FIN} flc_act_t;

  localparam int TW = flc_pkg::TMR_W;

  flc_state_t                    state_r;
  flc_pkg::flc_op_t              op_r;
  flc_pkg::flc_op_t              op_cur;
  flc_act_t                      act;
  logic [flc_pkg::ADDR_W-1:0]    addr_q;
  logic [flc_pkg::ADDR_W-1:0]    addr_cur;
  logic [flc_pkg::DATA_W-1:0]    wdata_q;
  logic [flc_pkg::DATA_W-1:0]    wdata_cur;
  logic                          step_r;
  logic                          q5_seen_r;
  logic                          armed_r;
  logic                          tmr_load_r;
  logic [TW-1:0]                 tmr_count_r;
  logic                          tmr_zero;
  logic                          tmr_done;
  logic                          refuse;
  logic                          fin_timeout;
  logic                          fin_reject;

  flc_wait #(.W(TW)) u_wait (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .load_i    (tmr_load_r),
    .count_i   (tmr_count_r),
    .zero_o    (tmr_zero)
  );

  assign tmr_done  = tmr_zero && !tmr_load_r;
  assign op_cur    = (state_r == S_IDLE) ? flc_pkg::flc_op_t'(op_i) : op_r;
  assign addr_cur  = (state_r == S_IDLE) ? addr_i : addr_q;
  assign wdata_cur = (state_r == S_IDLE) ? wdata_i : wdata_q;

  // Program and erase writes wait for a reset after a timeout; unprotect waits for a protect.
  assign refuse = (locked_o && (op_cur == flc_pkg::FLC_OP_WRITE ||
                                op_cur == flc_pkg::FLC_OP_CHK_WRITE))
                || (op_cur == flc_pkg::FLC_OP_UNPROTECT && !armed_r);

  //////////////////////////////////////////////////////////////////////////////////////////
  // Sequencing decision for the current cycle.
  always_comb begin
    act         = ACT_NONE;
    fin_timeout = 1'b0;
    fin_reject  = 1'b0;
    unique case (state_r)
      S_IDLE: begin
        if (start_i) begin
          if (refuse) begin
            act = ACT_FIN;
          end else begin
            unique case (op_cur)
              flc_pkg::FLC_OP_WRITE, flc_pkg::FLC_OP_RESET:        act = ACT_WR;
              flc_pkg::FLC_OP_PROTECT, flc_pkg::FLC_OP_UNPROTECT:  act = ACT_HV;
              default:                                            act = ACT_RD;
            endcase
          end
        end
      end
      S_WR_HIGH: begin
        if (tmr_done) begin
          act = (op_r == flc_pkg::FLC_OP_CHK_WRITE) ? ACT_RD : ACT_FIN;
        end
      end
      S_RD_END: begin
        unique case (op_r)
          flc_pkg::FLC_OP_POLL: begin
            if (!step_r) begin
              act = ACT_RD;
            end else if (rdata_o[flc_pkg::TOGGLE_BIT_ONE] == fl_dq_o[flc_pkg::TOGGLE_BIT_ONE]) begin
              act = ACT_FIN;
            end else if (rdata_o[flc_pkg::EXCEEDED_TIME_FLAG] && q5_seen_r) begin
              act         = ACT_FIN;
              fin_timeout = 1'b1;
            end else begin
              act = ACT_RD;
            end
          end
          flc_pkg::FLC_OP_CHK_WRITE: begin
            act        = step_r ? ACT_FIN : ACT_WR;
            fin_reject = step_r && rdata_o[flc_pkg::ERASE_WINDOW_FLAG];
          end
          default: act = ACT_FIN;
        endcase
      end
      S_HV_HOLD: begin
        if (tmr_done) begin
          act = ACT_FIN;
        end
      end
      default: act = ACT_NONE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Pin sequencer. During polling, fl_dq_o keeps the previous toggle sample while undriven.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r        <= S_IDLE;
      op_r           <= flc_pkg::FLC_OP_READ;
      addr_q         <= '0;
      wdata_q        <= '0;
      step_r         <= 1'b0;
      q5_seen_r      <= 1'b0;
      tmr_load_r     <= 1'b0;
      tmr_count_r    <= '0;
      busy_o         <= 1'b0;
      done_o         <= 1'b0;
      rdata_o        <= '0;
      timeout_o      <= 1'b0;
      rejected_o     <= 1'b0;
      refused_o      <= 1'b0;
      fl_addr_o      <= '0;
      fl_dq_o        <= '0;
      fl_dq_oe_o     <= 1'b0;
      fl_ce_n_o      <= 1'b1;
      fl_oe_n_o      <= 1'b1;
      fl_we_n_o      <= 1'b1;
      fl_oe_hv_o     <= 1'b0;
      fl_idmode_hv_o <= 1'b0;
    end else begin
      tmr_load_r <= 1'b0;
      done_o     <= 1'b0;
      if (state_r == S_IDLE && start_i) begin
        op_r      <= flc_pkg::flc_op_t'(op_i);
        addr_q    <= addr_i;
        wdata_q   <= wdata_i;
        step_r    <= 1'b0;
        q5_seen_r <= 1'b0;
      end
      // The end of every read records its samples; a following write step overwrites the toggle sample in fl_dq_o.
      if (state_r == S_RD_END) begin
        step_r <= 1'b1;
        fl_dq_o[flc_pkg::TOGGLE_BIT_ONE] <= rdata_o[flc_pkg::TOGGLE_BIT_ONE];
        if (rdata_o[flc_pkg::EXCEEDED_TIME_FLAG]) begin
          q5_seen_r <= 1'b1;
        end
      end
      unique case (act)
        ACT_RD: begin
          state_r        <= S_RD_LOW;
          busy_o         <= 1'b1;
          fl_addr_o      <= addr_cur;
          if (op_cur == flc_pkg::FLC_OP_VERIFY) begin
            fl_addr_o[flc_pkg::ID_SELECT_ADDRESS_BIT] <= 1'b1;
          end
          fl_idmode_hv_o <= (op_cur == flc_pkg::FLC_OP_VERIFY);
          fl_dq_oe_o     <= 1'b0;
          fl_ce_n_o      <= 1'b0;
          fl_oe_n_o      <= 1'b0;
          fl_we_n_o      <= 1'b1;
          tmr_load_r     <= 1'b1;
          tmr_count_r    <= TW'(flc_pkg::ACC_CYC);
        end
        ACT_WR: begin
          state_r     <= S_WR_LOW;
          busy_o      <= 1'b1;
          fl_addr_o   <= addr_cur;
          fl_dq_o     <= (op_cur == flc_pkg::FLC_OP_RESET) ? flc_pkg::RESET_CMD : wdata_cur;
          fl_dq_oe_o  <= 1'b1;
          fl_oe_n_o   <= 1'b1;
          fl_ce_n_o   <= 1'b0;
          fl_we_n_o   <= 1'b0;
          tmr_load_r  <= 1'b1;
          tmr_count_r <= TW'(flc_pkg::WP_CYC);
        end
        ACT_HV: begin
          state_r        <= S_HV_SETUP;
          busy_o         <= 1'b1;
          fl_addr_o      <= addr_cur;
          fl_addr_o[flc_pkg::PROTECT_SELECT_LINE] <= (op_cur == flc_pkg::FLC_OP_UNPROTECT);
          fl_oe_hv_o     <= 1'b1;
          fl_idmode_hv_o <= 1'b1;
          fl_ce_n_o      <= 1'b0;
          fl_oe_n_o      <= 1'b1;
          fl_we_n_o      <= 1'b1;
          tmr_load_r     <= 1'b1;
          tmr_count_r    <= TW'(flc_pkg::OES_CYC);
        end
        ACT_FIN: begin
          state_r        <= S_IDLE;
          busy_o         <= 1'b0;
          done_o         <= 1'b1;
          timeout_o      <= fin_timeout;
          rejected_o     <= fin_reject;
          refused_o      <= (state_r == S_IDLE);
          fl_dq_oe_o     <= 1'b0;
          fl_ce_n_o      <= 1'b1;
          fl_oe_n_o      <= 1'b1;
          fl_we_n_o      <= 1'b1;
          fl_oe_hv_o     <= 1'b0;
          fl_idmode_hv_o <= 1'b0;
        end
        default: begin
          unique case (state_r)
            S_WR_LOW: if (tmr_done) begin
              state_r     <= S_WR_HIGH;
              fl_we_n_o   <= 1'b1;
              fl_ce_n_o   <= 1'b1;
              tmr_load_r  <= 1'b1;
              tmr_count_r <= TW'(flc_pkg::WPH_CYC);
            end
            S_RD_LOW: if (tmr_done) begin
              state_r   <= S_RD_END;
              rdata_o   <= fl_dq_i;
              fl_ce_n_o <= 1'b1;
              fl_oe_n_o <= 1'b1;
            end
            S_HV_SETUP: if (tmr_done) begin
              state_r     <= S_HV_PULSE;
              fl_we_n_o   <= 1'b0;
              tmr_load_r  <= 1'b1;
              tmr_count_r <= TW'(PROT_PULSE_CYC);
            end
            S_HV_PULSE: if (tmr_done) begin
              state_r     <= S_HV_HOLD;
              fl_we_n_o   <= 1'b1;
              tmr_load_r  <= 1'b1;
              tmr_count_r <= TW'(flc_pkg::OES_CYC);
            end
            default: begin
            end
          endcase
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Timeout lock: set by a failed poll, cleared only by a completed reset command.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      locked_o <= 1'b0;
    end else if (act == ACT_FIN && fin_timeout) begin
      locked_o <= 1'b1;
    end else if (act == ACT_FIN && state_r != S_IDLE && op_r == flc_pkg::FLC_OP_RESET) begin
      locked_o <= 1'b0;
    end
  end

  // Unprotect is allowed only after a protect pass; it then needs a new one.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_r <= 1'b0;
    end else if (act == ACT_FIN && state_r != S_IDLE) begin
      if (op_r == flc_pkg::FLC_OP_PROTECT) begin
        armed_r <= 1'b1;
      end else if (op_r == flc_pkg::FLC_OP_UNPROTECT) begin
        armed_r <= 1'b0;
      end
    end
  end

  // Temporary unprotect level is registered into the reset high-voltage qualifier, one cycle later.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fl_reset_hv_o <= 1'b0;
    end else begin
      fl_reset_hv_o <= tmp_unprot_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_hv_pulse;
    $fell(fl_we_n_o) && fl_idmode_hv_o;
  endsequence

  a_lock_refuses_write: assert property (
    (state_r == S_IDLE && start_i && locked_o && op_i == 3'(flc_pkg::FLC_OP_WRITE))
    |=> done_o && refused_o && !fl_dq_oe_o)
    else $error("write accepted while timeout lock held");
  a_timeout_locks: assert property (done_o && timeout_o |-> locked_o)
    else $error("timeout did not set the lock");
  a_reset_unlocks: assert property (
    done_o && !refused_o && op_r == flc_pkg::FLC_OP_RESET |-> !locked_o)
    else $error("reset command did not clear the lock");
  a_reject_flag: assert property (done_o && rejected_o |-> rdata_o[flc_pkg::ERASE_WINDOW_FLAG])
    else $error("reject reported without erase-window flag high");
  a_protect_pins: assert property (
    s_hv_pulse and op_r == flc_pkg::FLC_OP_PROTECT
    |-> fl_oe_hv_o && !fl_ce_n_o && !fl_addr_o[flc_pkg::PROTECT_SELECT_LINE])
    else $error("protect pulse with wrong pin levels");
  a_unprotect_pins: assert property (
    s_hv_pulse and op_r == flc_pkg::FLC_OP_UNPROTECT
    |-> fl_oe_hv_o && !fl_ce_n_o && fl_addr_o[flc_pkg::PROTECT_SELECT_LINE])
    else $error("unprotect pulse with wrong pin levels");
  a_hv_pulse_held: assert property (s_hv_pulse |-> (!fl_we_n_o && fl_oe_hv_o) [*8])
    else $error("high-voltage pulse cut short");
  a_unprot_needs_protect: assert property (
    (state_r == S_IDLE && start_i && !armed_r && op_i == 3'(flc_pkg::FLC_OP_UNPROTECT))
    |=> done_o && refused_o)
    else $error("unprotect accepted without prior protect");
  a_write_gated: assert property (!fl_we_n_o && !fl_idmode_hv_o |-> !fl_ce_n_o && fl_oe_n_o)
    else $error("write strobe low without select or with output enable");

endmodule : flc_host

`default_nettype wire

/* File: bench/flc_flash_model.sv */
`default_nettype none

module flc_flash_model #(
  parameter logic [7:0] ID_CODE = 8'h5a  // Arbitrary identification value.
) (
  // Clock and reset.
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // Flash pins.
  input  wire logic [19:0] addr_i,
  input  wire logic [7:0]  dq_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        reset_hv_i,
  input  wire logic        oe_hv_i,
  input  wire logic        idmode_hv_i,
  output logic [7:0]       dq_o,
  // Bench controls and monitors.
  input  wire logic [3:0]  op_reads_i,
  output logic [7:0]       bad_strobe_o
);
  logic [7:0]  mem_r [16];
  logic [15:0] prot_r;
  logic [7:0]  held_r, last_r, dq_q, rd;
  logic [3:0]  left_r;
  logic [1:0]  seq_r;
  logic [19:0] addr_q;
  logic        busy_r, stuck_r, exc_r, tog_r, we_q, ce_q, oe_q, oehv_q;
  wire         reading  = !ce_n_i && !oe_n_i;
  wire         sec_prot = prot_r[addr_q[19:16]] && !reset_hv_i;
  wire         blank_ok = (mem_r[addr_q[3:0]] & dq_q) == dq_q;

  always_comb begin
    if (idmode_hv_i) begin
      rd = addr_i[1] ? {7'h00, prot_r[addr_i[19:16]]} : ID_CODE;
    end else if (busy_r) begin
      rd = {~last_r[7], tog_r, exc_r, 5'h00};
    end else begin
      rd = mem_r[addr_i[3:0]];
    end
  end
  // A released bus shows the inverse of the last value, never a stale copy.
  assign dq_o = reading ? rd : ~held_r;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) mem_r[i] <= 8'hff;
      {prot_r, held_r, last_r, dq_q, left_r, seq_r, addr_q} <= '0;
      {busy_r, stuck_r, exc_r, tog_r} <= 4'h0;
      {we_q, ce_q, oe_q, oehv_q} <= 4'he;
      bad_strobe_o <= 8'h00;
    end else begin
      {we_q, ce_q, oe_q, oehv_q} <= {we_n_i, ce_n_i, oe_n_i, oe_hv_i};
      addr_q <= addr_i;
      dq_q   <= dq_i;
      if (reading) held_r <= rd;
      if (!we_n_i && !oe_n_i && !oe_hv_i) bad_strobe_o <= bad_strobe_o + 8'h01;
      if (reading && oe_q && busy_r) begin
        tog_r <= ~tog_r;
        if (left_r != 4'h0) left_r <= left_r - 4'h1;
        else if (stuck_r) exc_r <= 1'b1;
        else busy_r <= 1'b0;
      end
      if (!we_q && we_n_i && !ce_q) begin
        if (oehv_q) begin
          if (addr_q[6]) prot_r <= '0;
          else prot_r[addr_q[19:16]] <= 1'b1;
        end else if (oe_q) begin
          if (dq_q == 8'hf0) begin
            {busy_r, exc_r, seq_r} <= 4'h0;
          end else if (busy_r) begin
            seq_r <= 2'h0;
          end else if (seq_r == 2'h3) begin
            seq_r <= 2'h0;
            if (!sec_prot) begin
              busy_r  <= 1'b1;
              left_r  <= op_reads_i;
              last_r  <= dq_q;
              stuck_r <= !blank_ok;
              if (blank_ok) mem_r[addr_q[3:0]] <= dq_q;
            end
          end else begin
            seq_r <= ({seq_r, dq_q} inside {10'h0aa, 10'h155, 10'h2a0}) ? seq_r + 2'h1 : 2'h0;
          end
        end
      end
    end
  end
endmodule : flc_flash_model

`default_nettype wire

/* File: bench/testbench.sv */
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        start_i = 1'b0;
  logic [2:0]  op_i = 3'h0;
  logic [19:0] addr_i = 20'h00000;
  logic [7:0]  wdata_i = 8'h00;
  logic        tmp_unprot_i = 1'b0;
  logic [3:0]  op_reads = 4'h2;
  logic        busy_o, done_o, timeout_o, rejected_o, refused_o, locked_o;
  logic [7:0]  rdata_o, fl_dq_i, fl_dq_o, bad_strobe;
  logic [19:0] fl_addr_o;
  logic        fl_dq_oe_o, fl_ce_n_o, fl_oe_n_o, fl_we_n_o;
  logic        fl_reset_hv_o, fl_oe_hv_o, fl_idmode_hv_o;
  int          bad_count = 0;
  int          compares = 0;
  int          cycles = 0;
  int          n;

  always #4 ref_clk_i = ~ref_clk_i;

  flc_host #(.PROT_PULSE_CYC(10)) u_flc_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .start_i(start_i), .op_i(op_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .tmp_unprot_i(tmp_unprot_i), .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o),
    .timeout_o(timeout_o), .rejected_o(rejected_o), .refused_o(refused_o),
    .locked_o(locked_o), .fl_addr_o(fl_addr_o), .fl_dq_i(fl_dq_i), .fl_dq_o(fl_dq_o),
    .fl_dq_oe_o(fl_dq_oe_o), .fl_ce_n_o(fl_ce_n_o), .fl_oe_n_o(fl_oe_n_o),
    .fl_we_n_o(fl_we_n_o), .fl_reset_hv_o(fl_reset_hv_o), .fl_oe_hv_o(fl_oe_hv_o),
    .fl_idmode_hv_o(fl_idmode_hv_o));

  flc_flash_model u_flc_flash_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .addr_i(fl_addr_o), .dq_i(fl_dq_o), .ce_n_i(fl_ce_n_o), .oe_n_i(fl_oe_n_o),
    .we_n_i(fl_we_n_o), .reset_hv_i(fl_reset_hv_o), .oe_hv_i(fl_oe_hv_o),
    .idmode_hv_i(fl_idmode_hv_o), .dq_o(fl_dq_i), .op_reads_i(op_reads),
    .bad_strobe_o(bad_strobe));

  task automatic tally_and_finish;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      $display("[ERR] %0t run too long", $time);
      tally_and_finish();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Issues one operation and waits for done; n holds the cycles it took.
  task automatic run(input flc_pkg::flc_op_t o, input logic [19:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    start_i <= 1'b1;
    op_i    <= o;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    start_i <= 1'b0;
    n = 1;
    forever begin
      @(negedge ref_clk_i);
      if (done_o === 1'b1 || n > 1000) break;
      n++;
    end
    chk(8'(done_o), 8'h01);
  endtask : run

  task automatic prog(input logic [19:0] a, input logic [7:0] d, input flc_pkg::flc_op_t o);
    run(flc_pkg::FLC_OP_WRITE, 20'h00555, 8'haa);
    run(flc_pkg::FLC_OP_WRITE, 20'h002aa, 8'h55);
    run(flc_pkg::FLC_OP_WRITE, 20'h00555, 8'ha0);
    run(o, a, d);
  endtask : prog

  task automatic t_read_mode;
    run(flc_pkg::FLC_OP_READ, 20'h00003, 8'h00);
    chk(8'(n), 8'h13);
    chk(rdata_o, 8'hff);
  endtask : t_read_mode

  task automatic t_partial;
    run(flc_pkg::FLC_OP_WRITE, 20'h00555, 8'haa);
    chk(8'(n), 8'h0f);
    run(flc_pkg::FLC_OP_WRITE, 20'h002aa, 8'h55);
    run(flc_pkg::FLC_OP_WRITE, 20'h00004, 8'h11);
    run(flc_pkg::FLC_OP_WRITE, 20'h00004, 8'h00);
    run(flc_pkg::FLC_OP_READ, 20'h00004, 8'h00);
    chk(rdata_o, 8'hff);
  endtask : t_partial

  task automatic t_program;
    prog(20'h00003, 8'h3c, flc_pkg::FLC_OP_CHK_WRITE);
    chk(8'(rejected_o), 8'h00);
    run(flc_pkg::FLC_OP_POLL, 20'h00003, 8'h00);
    chk(8'(timeout_o), 8'h00);
    run(flc_pkg::FLC_OP_READ, 20'h00003, 8'h00);
    chk(rdata_o, 8'h3c);
  endtask : t_program

  task automatic t_lockup;
    op_reads <= 4'h1;
    prog(20'h00003, 8'hc3, flc_pkg::FLC_OP_WRITE);
    run(flc_pkg::FLC_OP_POLL, 20'h00003, 8'h00);
    chk(8'(timeout_o), 8'h01);
    chk(8'(locked_o), 8'h01);
    run(flc_pkg::FLC_OP_WRITE, 20'h00003, 8'h00);
    chk(8'(refused_o), 8'h01);
    run(flc_pkg::FLC_OP_READ, 20'h00003, 8'h00);
    chk(rdata_o & 8'h20, 8'h20);
    run(flc_pkg::FLC_OP_RESET, 20'h00000, 8'h00);
    chk(8'(locked_o), 8'h00);
    run(flc_pkg::FLC_OP_READ, 20'h00003, 8'h00);
    chk(rdata_o, 8'h3c);
  endtask : t_lockup

  task automatic t_protect;
    run(flc_pkg::FLC_OP_UNPROTECT, 20'h00000, 8'h00);
    chk(8'(refused_o), 8'h01);
    run(flc_pkg::FLC_OP_PROTECT, 20'h20000, 8'h00);
    chk(8'(refused_o), 8'h00);
    run(flc_pkg::FLC_OP_VERIFY, 20'h20000, 8'h00);
    chk(rdata_o, 8'h01);
    run(flc_pkg::FLC_OP_VERIFY, 20'h10000, 8'h00);
    chk(rdata_o, 8'h00);
    prog(20'h20005, 8'h5a, flc_pkg::FLC_OP_WRITE);
    run(flc_pkg::FLC_OP_READ, 20'h20005, 8'h00);
    chk(rdata_o, 8'hff);
    @(posedge ref_clk_i);
    tmp_unprot_i <= 1'b1;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk(8'(fl_reset_hv_o), 8'h01);
    prog(20'h20005, 8'h5a, flc_pkg::FLC_OP_WRITE);
    run(flc_pkg::FLC_OP_POLL, 20'h20005, 8'h00);
    run(flc_pkg::FLC_OP_READ, 20'h20005, 8'h00);
    chk(rdata_o, 8'h5a);
    tmp_unprot_i <= 1'b0;
    run(flc_pkg::FLC_OP_UNPROTECT, 20'h00000, 8'h00);
    chk(8'(refused_o), 8'h00);
    run(flc_pkg::FLC_OP_VERIFY, 20'h20000, 8'h00);
    chk(rdata_o, 8'h00);
  endtask : t_protect

  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_read_mode();
    t_partial();
    t_program();
    t_lockup();
    t_protect();
    chk(bad_strobe, 8'h00);
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire
